//--- hw/lpmcg_pkg.sv
`default_nettype none
package lpmcg_pkg;

  // Operating states that software selects.
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_L0,
    MODE_L1,
    MODE_L2,
    MODE_L3,
    MODE_L4
  } lpmcg_mode_t;

  // Gate enables, one bit per clock or analog source.
  typedef struct packed {
    logic cpu;
    logic aclk;
    logic sub_main_clock;
    logic mclk;
    logic fll;
    logic dco_clk;
    logic dco_bias;
    logic xtal;
  } lpmcg_gate_t;

  localparam lpmcg_gate_t GATE_ALL_ON = 8'hff;
  localparam lpmcg_gate_t GATE_L0     = 8'h7f;
  localparam lpmcg_gate_t GATE_L1     = 8'h77;
  localparam lpmcg_gate_t GATE_L2     = 8'h43;
  localparam lpmcg_gate_t GATE_L3     = 8'h41;
  localparam lpmcg_gate_t GATE_L4     = 8'h00;

  localparam int         DIV_SEL_W  = 2;
  localparam int         DIV_CNT_W  = 3;
  localparam logic [2:0] DIV_CNT_RST = 3'h0;

  function automatic lpmcg_gate_t lpmcg_gate_for(lpmcg_mode_t m);
    unique case (m)
      MODE_RUN: return GATE_ALL_ON;
      MODE_L0:  return GATE_L0;
      MODE_L1:  return GATE_L1;
      MODE_L2:  return GATE_L2;
      MODE_L3:  return GATE_L3;
      MODE_L4:  return GATE_L4;
      default:  return GATE_ALL_ON;
    endcase
  endfunction

endpackage
`default_nettype wire

//--- hw/lpmcg_div_if.sv
`default_nettype none
interface lpmcg_div_if;
  import lpmcg_pkg::*;
  logic                 tick;
  logic                 run;
  logic [DIV_SEL_W-1:0] sel;
  logic                 pin_out;
  modport ctrl (output tick, output run, output sel, input pin_out);
  modport div  (input tick, input run, input sel, output pin_out);
endinterface
`default_nettype wire

//--- hw/lpmcg_clk_div.sv
`default_nettype none
module lpmcg_clk_div
  import lpmcg_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Divider control and output
  lpmcg_div_if.div dv
);

  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [DIV_CNT_W-1:0] cnt_next;
  logic                 pin_reg;
  logic                 pin_next;
  logic [DIV_CNT_W-1:0] limit;

  // Each tick marks one auxiliary clock edge, so the pin toggles once per
  // divisor ticks and its period is the divisor times the source period.
  assign limit = DIV_CNT_W'((4'h1 << dv.sel) - 4'h1);

  always_comb
  begin
    cnt_next = cnt_reg;
    pin_next = pin_reg;
    if (dv.run && dv.tick)
    begin
      if (cnt_reg >= limit)
      begin
        cnt_next = DIV_CNT_RST;
        pin_next = ~pin_reg;
      end
      else
        cnt_next = cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_reg <= DIV_CNT_RST;
      pin_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      pin_reg <= pin_next;
    end
  end

  assign dv.pin_out = pin_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_div_toggle: assert property (
    dv.run && dv.tick && cnt_reg >= limit |=> pin_reg != $past(pin_reg))
    else $error("divided clock missed its toggle");
  chk_div_hold: assert property (
    dv.run && dv.tick && cnt_reg < limit |=> pin_reg == $past(pin_reg))
    else $error("divided clock toggled early");
  chk_div_stop: assert property (
    !dv.run |=> pin_reg == $past(pin_reg))
    else $error("divided clock moved while stopped");

endmodule // lpmcg_clk_div
`default_nettype wire

//--- hw/lpmcg_ctrl.sv
// How it works
// - Full run keeps the core and every clock running.
// - Level 0 halts the core; aux, sub-main, main clocks and loop run.
// - Level 1 as level 0 but the frequency-lock loop is stopped.
// - Level 2 stops sub-main and main clocks, loop, oscillator output; bias stays on.
// - Level 3 also stops the oscillator bias; aux clock keeps running.
// - Level 4 stops everything including aux clock and crystal.
// - An interrupt wakes any sleep level; return resumes the saved level.
// - Aux clock on its pin is divided by 1, 2, 4 or 8.
`default_nettype none
module lpmcg_ctrl
  import lpmcg_pkg::*;
(
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Mode selection from the core
  input  wire logic                 mode_wr,
  input  wire logic [2:0]           mode_sel,
  // Interrupt entry and return
  input  wire logic                 irq_req,
  input  wire logic                 irq_ret,
  // Auxiliary clock pin
  input  wire logic                 aclk_tick,
  input  wire logic                 aclk_route,
  input  wire logic [DIV_SEL_W-1:0] aclk_div_sel,
  output logic                      aclk_pin_out,
  output logic                      aclk_pin_oe,
  // Gate enables
  output logic                      cpu_en,
  output logic                      aclk_en,
  output logic                      sub_main_clock_en,
  output logic                      mclk_en,
  output logic                      fll_en,
  output logic                      dco_clk_en,
  output logic                      dco_bias_en,
  output logic                      xtal_en,
  // Status
  output logic [2:0]                mode_now,
  output logic                      in_handler
);

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_ISR} lpmcg_state_t;

  lpmcg_state_t state_reg;
  lpmcg_state_t state_next;
  lpmcg_mode_t  mode_reg;
  lpmcg_mode_t  mode_next;
  lpmcg_gate_t  gate_reg;
  lpmcg_gate_t  gate_next;
  lpmcg_mode_t  sel_mode;
  logic         sel_ok;

  // Codes above the last sleep level are ignored rather than mapped.
  assign sel_ok   = mode_sel <= 3'(MODE_L4);
  assign sel_mode = lpmcg_mode_t'(mode_sel);

  always_comb
  begin
    state_next = state_reg;
    mode_next  = mode_reg;
    unique case (state_reg)
      ST_RUN:
      begin
        if (irq_req)
          state_next = ST_ISR;
        else if (mode_wr && sel_ok && sel_mode != MODE_RUN)
        begin
          mode_next  = sel_mode;
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (irq_req)
          state_next = ST_ISR;
      end
      ST_ISR:
      begin
        // A write here edits the level that the return will resume, as
        // a handler that changes the stacked status would.
        if (mode_wr && sel_ok)
          mode_next = sel_mode;
        if (irq_ret)
          state_next = (mode_next == MODE_RUN) ? ST_RUN : ST_SLEEP;
      end
      default:
        state_next = ST_RUN;
    endcase
    if (state_next == ST_RUN)
      mode_next = MODE_RUN;
  end

  always_comb
  begin
    if (state_next == ST_SLEEP)
      gate_next = lpmcg_gate_for(mode_next);
    else
      gate_next = GATE_ALL_ON;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_reg <= ST_RUN;
      mode_reg  <= MODE_RUN;
      gate_reg  <= GATE_ALL_ON;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      gate_reg  <= gate_next;
    end
  end

  assign cpu_en      = gate_reg.cpu;
  assign aclk_en     = gate_reg.aclk;
  assign sub_main_clock_en    = gate_reg.sub_main_clock;
  assign mclk_en     = gate_reg.mclk;
  assign fll_en      = gate_reg.fll;
  assign dco_clk_en  = gate_reg.dco_clk;
  assign dco_bias_en = gate_reg.dco_bias;
  assign xtal_en     = gate_reg.xtal;
  assign mode_now    = 3'(mode_reg);
  assign in_handler  = state_reg == ST_ISR;

  lpmcg_div_if div_bus ();

  assign div_bus.tick = aclk_tick;
  assign div_bus.run  = gate_reg.aclk;
  assign div_bus.sel  = aclk_div_sel;

  lpmcg_clk_div u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .dv      (div_bus)
  );

  // The pin only shows the divided clock while routed to it.
  assign aclk_pin_out = aclk_route & div_bus.pin_out;
  assign aclk_pin_oe  = aclk_route;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_run_all_on: assert property (
    state_reg == ST_RUN |-> gate_reg == GATE_ALL_ON && mode_reg == MODE_RUN)
    else $error("full run with a clock gated");
  chk_level0_gates: assert property (
    state_reg == ST_SLEEP && mode_reg == MODE_L0 |->
      !cpu_en && aclk_en && sub_main_clock_en && mclk_en && fll_en)
    else $error("level 0 gating wrong");
  chk_level1_gates: assert property (
    state_reg == ST_SLEEP && mode_reg == MODE_L1 |->
      !cpu_en && aclk_en && sub_main_clock_en && mclk_en && !fll_en)
    else $error("level 1 gating wrong");
  chk_level2_gates: assert property (
    state_reg == ST_SLEEP && mode_reg == MODE_L2 |->
      !cpu_en && !mclk_en && !fll_en && !dco_clk_en && dco_bias_en
      && aclk_en)
    else $error("level 2 gating wrong");
  chk_level3_gates: assert property (
    state_reg == ST_SLEEP && mode_reg == MODE_L3 |->
      !cpu_en && !mclk_en && !fll_en && !dco_clk_en && !dco_bias_en
      && aclk_en)
    else $error("level 3 gating wrong");
  chk_level4_gates: assert property (
    state_reg == ST_SLEEP && mode_reg == MODE_L4 |->
      gate_reg == GATE_L4 && !xtal_en && !aclk_en)
    else $error("level 4 gating wrong");
  chk_sleep_wake: assert property (
    state_reg == ST_SLEEP && irq_req |=> in_handler && cpu_en)
    else $error("interrupt did not wake the core");
  chk_resume_level: assert property (
    in_handler && irq_ret && !mode_wr && mode_reg != MODE_RUN |=>
      state_reg == ST_SLEEP && mode_reg == $past(mode_reg)
      && gate_reg == lpmcg_gate_for($past(mode_reg)))
    else $error("return did not resume the saved level");
  chk_isr_full_run: assert property (
    in_handler |-> gate_reg == GATE_ALL_ON)
    else $error("handler ran with clocks gated");
  chk_select_sleep: assert property (
    state_reg == ST_RUN && !irq_req && mode_wr && sel_ok
      && mode_sel != 3'h0 |=> state_reg == ST_SLEEP && !cpu_en
      && mode_now == $past(mode_sel))
    else $error("software selection not applied");
  chk_pin_oe: assert property (
    aclk_pin_oe == aclk_route)
    else $error("aux clock pin enable wrong");

  cov_sleep_l4_wake: cover property (
    state_reg == ST_SLEEP && mode_reg == MODE_L4 ##1 in_handler);
  cov_resume_l2: cover property (
    in_handler && mode_reg == MODE_L2 ##1 state_reg == ST_SLEEP);
  cov_run_irq: cover property (state_reg == ST_RUN ##1 in_handler
    ##[1:20] state_reg == ST_RUN);
  cov_div8_toggle: cover property (
    aclk_route && aclk_div_sel == 2'h3 && $rose(aclk_pin_out));

endmodule // lpmcg_ctrl
`default_nettype wire

//--- tb/lpmcg_core_model.sv
`default_nettype none
module lpmcg_core_model
(
  // Clock
  input  wire logic       sys_clk,
  // Requests to the controller
  output var  logic       mode_wr,
  output var  logic [2:0] mode_sel,
  output var  logic       irq_req,
  output var  logic       irq_ret,
  // Handler status
  input  wire logic       in_handler
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    mode_wr = 1'h0;
    mode_sel = 3'h0;
    irq_req = 1'h0;
    irq_ret = 1'h0;
  end

  // The select lines are scrambled after the pulse so stale values never help.
  task automatic write_mode(input logic [2:0] sel);
    @(posedge sys_clk);
    #1;
    mode_wr = 1'h1;
    mode_sel = sel;
    @(posedge sys_clk);
    #1;
    mode_wr = 1'h0;
    mode_sel = ~sel;
  endtask

  // An interrupt flag stays set until the controller takes it or eight cycles pass.
  task automatic raise_irq(output logic ok);
    ok = 1'h0;
    @(posedge sys_clk);
    #1;
    irq_req = 1'h1;
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(posedge sys_clk);
      #1;
      ok = (in_handler === 1'h1);
    end
    irq_req = 1'h0;
  endtask

  task automatic leave_irq();
    @(posedge sys_clk);
    #1;
    irq_ret = 1'h1;
    @(posedge sys_clk);
    #1;
    irq_ret = 1'h0;
  endtask
endmodule // lpmcg_core_model
`default_nettype wire

//--- tb/testbench.sv
`default_nettype none
module testbench;
  import lpmcg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] gate;
  } lpmcg_row_t;

  // Level 3 comes last: it resumes sleep after the handler returns.
  lpmcg_row_t rows [5] = '{'{3'h1, 8'h7f}, '{3'h2, 8'h77},
    '{3'h3, 8'h43}, '{3'h5, 8'h00}, '{3'h4, 8'h41}};
  logic                 sys_clk      = 1'h0;
  logic                 rst          = 1'h1;
  logic                 aclk_tick    = 1'h0;
  logic                 aclk_route   = 1'h0;
  logic [DIV_SEL_W-1:0] aclk_div_sel = 2'h0;
  logic                 mode_wr, irq_req, irq_ret;
  logic [2:0]           mode_sel, mode_now;
  logic                 aclk_pin_out, aclk_pin_oe, in_handler, ok, last;
  logic                 cpu_en, aclk_en, sub_main_clock_en, mclk_en;
  logic                 fll_en, dco_clk_en, dco_bias_en, xtal_en;
  logic [7:0]           gates;
  int                   err_total, num_checks, toggles;

  assign gates = {cpu_en, aclk_en, sub_main_clock_en, mclk_en,
                  fll_en, dco_clk_en, dco_bias_en, xtal_en};

  always #5 sys_clk = ~sys_clk;

  lpmcg_core_model lpmcg_core_model_inst (.sys_clk(sys_clk),
    .mode_wr(mode_wr), .mode_sel(mode_sel), .irq_req(irq_req),
    .irq_ret(irq_ret), .in_handler(in_handler));

  lpmcg_ctrl lpmcg_ctrl_inst (.sys_clk(sys_clk), .rst(rst),
    .mode_wr(mode_wr), .mode_sel(mode_sel), .irq_req(irq_req),
    .irq_ret(irq_ret), .aclk_tick(aclk_tick), .aclk_route(aclk_route),
    .aclk_div_sel(aclk_div_sel), .aclk_pin_out(aclk_pin_out),
    .aclk_pin_oe(aclk_pin_oe), .cpu_en(cpu_en), .aclk_en(aclk_en),
    .sub_main_clock_en(sub_main_clock_en), .mclk_en(mclk_en), .fll_en(fll_en),
    .dco_clk_en(dco_clk_en), .dco_bias_en(dco_bias_en),
    .xtal_en(xtal_en), .mode_now(mode_now), .in_handler(in_handler));

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // A wake that never lands is counted once and ends the run.
  task automatic wake();
    lpmcg_core_model_inst.raise_irq(ok);
    check("wake taken", 8'h01, {7'h0, ok});
    if (ok !== 1'h1)
      conclude();
  endtask

  task automatic settle();
    @(posedge sys_clk);
    #1;
  endtask

  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'h0;
    check("reset gates", 8'hff, gates);
    check("reset mode", 8'h00, {5'h0, mode_now});
    check("reset pin", 8'h00, {7'h0, aclk_pin_out});
    $display("test reset done");
    foreach (rows[i])
    begin
      lpmcg_core_model_inst.write_mode(rows[i].sel);
      settle();
      check("sleep gates", rows[i].gate, gates);
      check("sleep mode", {5'h0, rows[i].sel}, {5'h0, mode_now});
      wake();
      check("handler gates", 8'hff, gates);
      check("saved mode", {5'h0, rows[i].sel}, {5'h0, mode_now});
      if (rows[i].sel != 3'h4)
        lpmcg_core_model_inst.write_mode(3'h0);
      lpmcg_core_model_inst.leave_irq();
      settle();
      check("handler flag", 8'h00, {7'h0, in_handler});
      check("resume gates", rows[i].sel == 3'h4 ? rows[i].gate : 8'hff,
            gates);
    end
    $display("test sleep levels done");
    wake();
    lpmcg_core_model_inst.write_mode(3'h0);
    lpmcg_core_model_inst.leave_irq();
    lpmcg_core_model_inst.write_mode(3'h6);
    settle();
    check("bad select", 8'hff, gates);
    lpmcg_core_model_inst.write_mode(3'h3);
    rst = 1'h1;
    repeat (2) settle();
    rst = 1'h0;
    check("mid reset", 8'hff, gates);
    check("mid reset state", 8'h00, {4'h0, in_handler, mode_now});
    $display("test refusal and reset done");
    aclk_tick = 1'h1;
    aclk_route = 1'h1;
    for (int d = 0; d < 4; d++)
    begin
      aclk_div_sel = d[1:0];
      repeat (20) settle();
      toggles = 0;
      last = aclk_pin_out;
      repeat (32)
      begin
        settle();
        if (aclk_pin_out !== last)
          toggles++;
        last = aclk_pin_out;
      end
      check("pin toggles", 8'(32 >> d), 8'(toggles));
      check("pin enable", 8'h01, {7'h0, aclk_pin_oe});
    end
    // A handler entered from full run picks level 4 for the return, so the
    // divided pin must freeze although ticks keep arriving.
    wake();
    check("run handler mode", 8'h00, {5'h0, mode_now});
    lpmcg_core_model_inst.write_mode(3'h5);
    lpmcg_core_model_inst.leave_irq();
    settle();
    check("edited level", 8'h00, gates);
    toggles = 0;
    last = aclk_pin_out;
    repeat (16)
    begin
      settle();
      if (aclk_pin_out !== last)
        toggles++;
      last = aclk_pin_out;
    end
    check("frozen pin", 8'h00, 8'(toggles));
    wake();
    check("level 4 saved", 8'h05, {5'h0, mode_now});
    lpmcg_core_model_inst.write_mode(3'h0);
    lpmcg_core_model_inst.leave_irq();
    settle();
    check("back to run", 8'hff, gates);
    $display("test handler edit done");
    aclk_route = 1'h0;
    settle();
    check("pin off", 8'h00, {6'h0, aclk_pin_oe, aclk_pin_out});
    $display("test divider done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
